//--- dv/dbg_checker.sv
`timescale 1ns/1ps
module dbg_checker (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [1:0] current_privilege_level,
   input wire logic debug_extensions_enable,
   input wire logic move_valid,
   input wire logic move_write,
   input wire logic [2:0] move_slot,
   input wire logic insn_retired,
   input wire logic single_step_flag,
   input wire logic task_switch,
   input wire logic task_trap_bit,
   input wire logic breakpoint_instruction,
   input wire logic move_done,
   input wire dbg_pkg::fault_type move_fault,
   input wire logic debug_trap,
   input wire logic breakpoint_trap,
   input wire logic [63:0] debug_status_reg,
   input wire logic [63:0] debug_control_reg
);
   import dbg_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // Request and trap steps
   sequence s_priv;
      move_valid && current_privilege_level == 2'h0;
   endsequence
   sequence s_trap(int b);
      debug_trap && debug_status_reg[b];
   endsequence
   step_trap_a: assert property (insn_retired && single_step_flag |=> s_trap(ST_STEP)) else $error("step trap missing");
   task_trap_a: assert property (task_switch && task_trap_bit |=> s_trap(ST_TASK)) else $error("task trap missing");
   move_answer_a: assert property (move_valid && !debug_control_reg[CT_GD] |=> move_done) else $error("move not answered");
   prot_fault_a: assert property (move_valid && current_privilege_level != 2'h0 |=> move_fault == FAULT_PROT) else $error("no protection fault");
   alias_fault_a: assert property (s_priv ##0 debug_extensions_enable && move_slot inside {3'h4, 3'h5} |=> move_fault == FAULT_OPCODE) else $error("no opcode fault");
   detect_fault_a: assert property (s_priv ##0 move_slot < 3'h4 && debug_control_reg[CT_GD] |=> s_trap(ST_ACCESS) and move_fault == FAULT_GDET) else $error("no detect trap");
   brk_trap_a: assert property (breakpoint_instruction |=> breakpoint_trap) else $error("no breakpoint trap");
   gd_clear_a: assert property (debug_trap |-> !debug_control_reg[CT_GD]) else $error("detect not cleared");
   fixed_bits_a: assert property ((debug_status_reg & (ST_FIXED | 64'hffff_ffff_0000_0000)) == ST_ONES) else $error("fixed status bits");
   sticky_bits_a: assert property (|($past(debug_status_reg) & ~debug_status_reg & ST_STICKY) |-> $past(move_valid && move_write)) else $error("sticky bit dropped");
endmodule
bind debug_breakpoint_status_unit dbg_checker chk_i (.*);

//--- dv/exec_core_model.sv
`timescale 1ns/1ps
// Core side that issues control transfers on request
module exec_core_model (
   input wire logic core_clk,
   input wire logic go,
   input wire logic [63:0] from_addr,
   input wire logic [63:0] to_addr,
   output logic xfer_valid,
   output logic [63:0] xfer_from,
   output logic [63:0] xfer_to
);
   initial begin
      xfer_valid = 1'b0;
      xfer_from = 64'h0;
      xfer_to = 64'h0;
   end
   // One pulse per request; buses show inverted junk between pulses
   always @(negedge core_clk) begin
      xfer_valid <= go;
      xfer_from <= go ? from_addr : ~xfer_from;
      xfer_to <= go ? to_addr : ~xfer_to;
   end
endmodule

//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import dbg_pkg::*;
   logic core_clk = 1'b0, rstn = 1'b0, mode_64 = 1'b1, long_mode = 1'b1;
   logic [1:0] current_privilege_level = 2'h0, ref_kind = 2'h0;
   logic debug_extensions_enable = 1'b0, move_valid = 1'b0, move_write = 1'b0;
   logic [2:0] move_slot = 3'h0;
   logic [63:0] move_wdata = 64'h0, ref_addr = 64'h0, fa = 64'h0, ta = 64'h0;
   logic ref_valid = 1'b0, insn_retired = 1'b0, single_step_flag = 1'b0;
   logic task_switch = 1'b0, task_trap_bit = 1'b0, go = 1'b0;
   logic breakpoint_instruction = 1'b0, xfer_valid, trp, brk;
   logic [63:0] xfer_from, xfer_to, move_rdata, rd, v;
   logic [63:0] debug_status_reg, debug_control_reg;
   logic [63:0] last_xfer_from, last_xfer_to;
   logic move_done, debug_trap, breakpoint_trap;
   fault_type move_fault, flt;
   logic [31:0] seed = 32'h34147a3b;
   int miscompares = 0, total_checks = 0, cycles = 0;
   debug_breakpoint_status_unit dut (.*);
   exec_core_model core (.core_clk(core_clk), .go(go), .from_addr(fa),
      .to_addr(ta), .xfer_valid(xfer_valid), .xfer_from(xfer_from),
      .xfer_to(xfer_to));
   // Clock and hang guard
   always #20 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Expected read under the current mode, and a status write image
   function automatic logic [63:0] exp_rd(input logic [63:0] d);
      return mode_64 ? d : {32'h0, d[31:0]};
   endfunction
   function automatic logic [63:0] exp_st(input logic [31:0] d);
      return ({32'h0, d} & ~ST_FIXED) | ST_ONES;
   endfunction
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // One register move; answer taken one cycle later
   task automatic mv(input logic w, input logic [2:0] s, input logic [63:0] d);
      @(negedge core_clk);
      move_valid = 1'b1;
      move_write = w;
      move_slot = s;
      move_wdata = d;
      @(negedge core_clk);
      move_valid = 1'b0;
      rd = move_rdata;
      flt = move_fault;
      trp = debug_trap;
   endtask
   // Pulse of reference, retire, task switch or breakpoint instruction
   task automatic ev(input logic [3:0] k);
      @(negedge core_clk);
      {ref_valid, insn_retired, task_switch, breakpoint_instruction} = k;
      @(negedge core_clk);
      {ref_valid, insn_retired, task_switch, breakpoint_instruction} = 4'h0;
      trp = debug_trap;
      brk = breakpoint_trap;
   endtask
   initial begin
      repeat (20) @(posedge core_clk);
      @(negedge core_clk);
      rstn = 1'b1;
      chk(debug_status_reg, STATUS_RESET);
      chk(debug_control_reg, CONTROL_RESET);
      // Address registers, slots 0 and 2 in 32-bit mode and slots 1 and 3 in 64-bit mode, random non-canonical values
      for (int i = 0; i < 8; i++) begin
         mode_64 = i[0];
         v = {rnd(), rnd()};
         mv(1'b1, i[1:0], v);
         mv(1'b0, i[1:0], 64'h0);
         chk(rd, exp_rd(v));
      end
      // Moves from every less privileged level are refused
      for (int i = 1; i < 4; i++) begin
         current_privilege_level = i[1:0];
         mv(1'b1, 3'h3, ~v);
         chk(flt, FAULT_PROT);
         chk(rd, 64'h0);
      end
      current_privilege_level = 2'h0;
      mv(1'b0, 3'h3, 64'h0);
      chk(rd, v);
      mv(1'b0, SLOT_STATUS_ALIAS, 64'h0);
      chk(rd, STATUS_RESET);
      mv(1'b0, SLOT_CONTROL_ALIAS, 64'h0);
      chk(rd, CONTROL_RESET);
      debug_extensions_enable = 1'b1;
      mv(1'b0, SLOT_STATUS_ALIAS, 64'h0);
      chk(flt, FAULT_OPCODE);
      mv(1'b1, SLOT_CONTROL_ALIAS, 64'h0);
      chk(flt, FAULT_OPCODE);
      debug_extensions_enable = 1'b0;
      mv(1'b1, SLOT_STATUS, 64'h1_0000_0000);
      chk(flt, FAULT_PROT);
      v = {32'h0, rnd()};
      mv(1'b1, SLOT_STATUS, v);
      mv(1'b0, SLOT_STATUS, 64'h0);
      chk(rd, exp_st(v[31:0]));
      mv(1'b1, SLOT_STATUS, 64'h0);
      // Slot one hit with its global enable, then with none
      v = {rnd(), rnd()};
      mv(1'b1, 3'h1, v);
      mv(1'b1, SLOT_CONTROL, 64'h408);
      ref_addr = v;
      ref_kind = RW_EXEC;
      ev(4'h8);
      chk(trp, 1'b1);
      chk(debug_status_reg[3:0], 4'h2);
      mv(1'b1, SLOT_CONTROL, CONTROL_RESET);
      ev(4'h8);
      chk(trp, 1'b0);
      single_step_flag = 1'b1;
      ev(4'h4);
      chk(trp, 1'b1);
      chk(debug_status_reg[ST_STEP], 1'b1);
      single_step_flag = 1'b0;
      task_trap_bit = 1'b1;
      ev(4'h2);
      chk(trp, 1'b1);
      chk(debug_status_reg[15:14], 2'h3);
      mv(1'b1, SLOT_CONTROL, 64'h2400);
      mv(1'b0, 3'h0, 64'h0);
      chk(flt, FAULT_GDET);
      chk(debug_status_reg[15:13], 3'h7);
      chk(debug_status_reg[3:0], 4'h0);
      chk(debug_control_reg[CT_GD], 1'b0);
      mv(1'b1, SLOT_STATUS, 64'h0);
      chk(debug_status_reg, ST_ONES);
      ev(4'h1);
      chk(brk, 1'b1);
      fa = {rnd(), rnd()};
      ta = {rnd(), rnd()};
      @(negedge core_clk) go <= 1'b1;
      @(negedge core_clk) go <= 1'b0;
      repeat (2) @(negedge core_clk);
      chk(last_xfer_from, fa);
      chk(last_xfer_to, ta);
      tally_and_finish();
   end
endmodule

//--- pkg/bp_match_if.sv
`timescale 1ns/1ps
// Carries breakpoint settings in and per-slot hits out
interface bp_match_if;
   logic [63:0] addr [4];
   logic [63:0] control;
   logic io_enabled;
   logic long_mode;
   logic ref_valid;
   logic [63:0] ref_addr;
   logic [1:0] ref_kind;
   logic [3:0] hits;
   modport owner (output addr, control, io_enabled, long_mode, ref_valid,
      ref_addr, ref_kind, input hits);
   modport matcher (input addr, control, io_enabled, long_mode, ref_valid,
      ref_addr, ref_kind, output hits);
endinterface

//--- pkg/dbg_pkg.sv
package dbg_pkg;
   // Register slot numbers for a debug register move
   localparam logic [2:0] SLOT_BP0 = 3'h0;
   localparam logic [2:0] SLOT_BP3 = 3'h3;
   localparam logic [2:0] SLOT_STATUS_ALIAS = 3'h4;
   localparam logic [2:0] SLOT_CONTROL_ALIAS = 3'h5;
   localparam logic [2:0] SLOT_STATUS = 3'h6;
   localparam logic [2:0] SLOT_CONTROL = 3'h7;
   // Status register fields and fixed bits
   localparam int ST_TASK = 15;
   localparam int ST_STEP = 14;
   localparam int ST_ACCESS = 13;
   localparam logic [63:0] ST_ONES = 64'h0000_0000_ffff_0ff0;
   localparam logic [63:0] ST_FIXED = 64'h0000_0000_ffff_1ff0;
   localparam logic [63:0] ST_STICKY = 64'h0000_0000_0000_e000;
   // Control register fields and fixed bits
   localparam int CT_GD = 13;
   localparam int CT_RW_LSB = 16;
   localparam int CT_LEN_LSB = 18;
   localparam logic [63:0] CT_ONES = 64'h0000_0000_0000_0400;
   localparam logic [63:0] CT_ZEROS = 64'hffff_ffff_0000_d800;
   localparam logic [63:0] CT_LOCAL = 64'h0000_0000_0000_0055;
   localparam logic [63:0] STATUS_RESET = 64'h0000_0000_ffff_0ff0;
   localparam logic [63:0] CONTROL_RESET = 64'h0000_0000_0000_0400;
   localparam int PRIV_TOP = 0;
   // Access types
   localparam logic [1:0] RW_EXEC = 2'h0;
   localparam logic [1:0] RW_WRITE = 2'h1;
   localparam logic [1:0] RW_IO = 2'h2;
   localparam logic [1:0] RW_RDWR = 2'h3;
   // Fault codes reported for a move
   typedef enum logic [1:0] {
      FAULT_NONE, FAULT_PROT, FAULT_OPCODE, FAULT_GDET
   } fault_type;
endpackage

//--- rtl/bp_matcher.sv
`timescale 1ns/1ps
// Compares one reference with the four breakpoint slots
module bp_matcher #(
   parameter int SLOTS = 4
) (
   bp_match_if.matcher m
);
   import dbg_pkg::*;

   // Refuse slot counts that the four-bit hit vector cannot serve
   generate
      if (SLOTS < 1 || SLOTS > 4) begin : g_bad_slots
         $error("bp_matcher supports one to four slots");
      end
   endgenerate

   // One comparator per slot, masked by its length field
   genvar i;
   generate
      for (i = 0; i < SLOTS; i++) begin : g_slot
         logic [1:0] rw;
         logic [1:0] len;
         logic [63:0] mask;
         logic kind_ok;
         assign rw = m.control[CT_RW_LSB + 4*i +: 2];
         assign len = m.control[CT_LEN_LSB + 4*i +: 2];
         always_comb begin
            unique case (len)
               2'h0: mask = 64'hffff_ffff_ffff_ffff;
               2'h1: mask = 64'hffff_ffff_ffff_fffe;
               2'h2: mask = m.long_mode ? 64'hffff_ffff_ffff_fff8
                  : 64'hffff_ffff_ffff_ffff;
               2'h3: mask = 64'hffff_ffff_ffff_fffc;
            endcase
            kind_ok = (rw == RW_EXEC && m.ref_kind == RW_EXEC)
               || (rw == RW_WRITE && m.ref_kind == RW_WRITE)
               || (rw == RW_IO && m.io_enabled && m.ref_kind == RW_IO)
               || (rw == RW_RDWR
                  && (m.ref_kind == RW_WRITE || m.ref_kind == RW_RDWR));
         end
         // Hit regardless of enables; enables gate the trap
         assign m.hits[i] = m.ref_valid && kind_ok
            && ((m.ref_addr & mask) == (m.addr[i] & mask));
      end
      for (i = SLOTS; i < 4; i++) begin : g_none
         assign m.hits[i] = 1'b0;
      end
   endgenerate
endmodule

//--- rtl/debug_breakpoint_status_unit.sv
`timescale 1ns/1ps
module debug_breakpoint_status_unit (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic mode_64,
   input wire logic long_mode,
   input wire logic [1:0] current_privilege_level,
   input wire logic debug_extensions_enable,
   input wire logic move_valid,
   input wire logic move_write,
   input wire logic [2:0] move_slot,
   input wire logic [63:0] move_wdata,
   input wire logic ref_valid,
   input wire logic [1:0] ref_kind,
   input wire logic [63:0] ref_addr,
   input wire logic insn_retired,
   input wire logic single_step_flag,
   input wire logic task_switch,
   input wire logic task_trap_bit,
   input wire logic breakpoint_instruction,
   input wire logic xfer_valid,
   input wire logic [63:0] xfer_from,
   input wire logic [63:0] xfer_to,
   output logic move_done,
   output logic [63:0] move_rdata,
   output dbg_pkg::fault_type move_fault,
   output logic debug_trap,
   output logic breakpoint_trap,
   output logic [63:0] debug_status_reg,
   output logic [63:0] debug_control_reg,
   output logic [63:0] last_xfer_from,
   output logic [63:0] last_xfer_to
);
   import dbg_pkg::*;

   typedef struct packed {
      logic [3:0][63:0] bp;
      logic [63:0] status;
      logic [63:0] control;
      logic done;
      logic [63:0] rdata;
      fault_type fault;
      logic trap;
      logic bp_trap;
      logic [63:0] from;
      logic [63:0] to;
   } state_type;

   state_type cur;
   state_type next_state;

   // Address comparators shared through the match interface
   bp_match_if mi ();
   generate
      for (genvar k = 0; k < 4; k++) begin : g_addr
         assign mi.addr[k] = cur.bp[k];
      end
   endgenerate
   assign mi.control = cur.control;
   assign mi.io_enabled = debug_extensions_enable;
   assign mi.long_mode = long_mode;
   assign mi.ref_valid = ref_valid;
   assign mi.ref_addr = ref_addr;
   assign mi.ref_kind = ref_kind;

   bp_matcher #(.SLOTS(4)) u_match (
      .m(mi.matcher)
   );

   logic [3:0] enabled;
   logic [3:0] gated;
   logic step_ev;
   logic task_ev;
   logic gd_ev;
   logic priv_ok;
   logic alias_bad;
   logic upper_bad;
   logic [2:0] eff_slot;
   logic [63:0] wval;
   logic [63:0] rval;

   // Local or global enable per slot gates each trap
   generate
      for (genvar j = 0; j < 4; j++) begin : g_en
         assign enabled[j] = cur.control[2*j] | cur.control[2*j+1];
      end
   endgenerate
   assign gated = mi.hits & enabled;

   // Move checks and slot resolution
   always_comb begin
      priv_ok = (current_privilege_level == 2'(PRIV_TOP));
      alias_bad = debug_extensions_enable
         && (move_slot == SLOT_STATUS_ALIAS
         || move_slot == SLOT_CONTROL_ALIAS);
      if (move_slot == SLOT_STATUS_ALIAS) begin
         eff_slot = SLOT_STATUS;
      end else if (move_slot == SLOT_CONTROL_ALIAS) begin
         eff_slot = SLOT_CONTROL;
      end else begin
         eff_slot = move_slot;
      end
      // Upper half is zero-filled outside 64-bit mode
      wval = mode_64 ? move_wdata : {32'h0, move_wdata[31:0]};
      upper_bad = mode_64 && move_write && (move_wdata[63:32] != 32'h0)
         && (eff_slot == SLOT_STATUS || eff_slot == SLOT_CONTROL);
      gd_ev = move_valid && priv_ok && !alias_bad
         && cur.control[CT_GD];
      step_ev = insn_retired && single_step_flag;
      task_ev = task_switch && task_trap_bit;
      if (eff_slot <= SLOT_BP3) begin
         rval = cur.bp[eff_slot[1:0]];
      end else if (eff_slot == SLOT_STATUS) begin
         rval = cur.status;
      end else begin
         rval = cur.control;
      end
   end

   // Next-state logic for registers, traps and move answers
   always_comb begin
      next_state = cur;
      next_state.done = 1'b0;
      next_state.fault = FAULT_NONE;
      next_state.trap = 1'b0;
      next_state.bp_trap = breakpoint_instruction;
      // Record each control transfer for later reading
      if (xfer_valid) begin
         next_state.from = xfer_from;
         next_state.to = xfer_to;
      end
      // Register move, with faults in priority order
      if (move_valid) begin
         next_state.done = 1'b1;
         next_state.rdata = 64'h0;
         if (!priv_ok) begin
            next_state.fault = FAULT_PROT;
         end else if (alias_bad) begin
            next_state.fault = FAULT_OPCODE;
         end else if (cur.control[CT_GD]) begin
            next_state.fault = FAULT_GDET;
         end else if (upper_bad) begin
            next_state.fault = FAULT_PROT;
         end else if (!move_write) begin
            next_state.rdata = mode_64 ? rval
               : {32'h0, rval[31:0]};
         end else if (eff_slot <= SLOT_BP3) begin
            next_state.bp[eff_slot[1:0]] = wval;
         end else if (eff_slot == SLOT_STATUS) begin
            // Fixed bits forced; software alone clears 15:13
            next_state.status = (wval & ~ST_FIXED) | ST_ONES;
         end else begin
            next_state.control = (wval & ~CT_ZEROS) | CT_ONES;
         end
      end
      // Task switch clears local enables
      if (task_switch) begin
         next_state.control = next_state.control & ~CT_LOCAL;
      end
      // Trap taken: all causes written at once
      if (step_ev || task_ev || gd_ev || (|gated)) begin
         next_state.trap = 1'b1;
         if (gd_ev || (|gated)) begin
            next_state.status[3:0] = gated;
         end
         if (gd_ev) begin
            next_state.status[ST_ACCESS] = 1'b1;
         end
         if (step_ev) begin
            next_state.status[ST_STEP] = 1'b1;
         end
         if (task_ev) begin
            next_state.status[ST_TASK] = 1'b1;
         end
         next_state.control[CT_GD] = 1'b0;
      end
   end

   // State register
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cur <= '{bp: '0, status: STATUS_RESET, control: CONTROL_RESET,
            done: 1'b0, rdata: 64'h0, fault: FAULT_NONE, trap: 1'b0,
            bp_trap: 1'b0, from: 64'h0, to: 64'h0};
      end else begin
         cur <= next_state;
      end
   end

   assign move_done = cur.done;
   assign move_rdata = cur.rdata;
   assign move_fault = cur.fault;
   assign debug_trap = cur.trap;
   assign breakpoint_trap = cur.bp_trap;
   assign debug_status_reg = cur.status;
   assign debug_control_reg = cur.control;
   assign last_xfer_from = cur.from;
   assign last_xfer_to = cur.to;
endmodule
